// file: src/ledwp_top.sv
// parallel write port of an 8-digit seven-segment display driver
// assumes write pins from outside the clock domain, an apb master on i_mclk
//
// What this block does
// RQ1 - In the register variant a rising write strobe captures the byte into the control word or display ram.
// RQ2 - Target select high loads the control word and low loads the display ram.
// RQ3 - Control bit four high keeps normal operation and low stops the oscillator and blanks the display.
// RQ4 - A register-variant ram write puts input lines zero to seven into data bits zero to seven in order.
// RQ5 - With the pending bit low, control lines zero to two give the digit address, line zero least significant.
// RQ6 - Control bit three picks ram bank A when high and bank B when low; undecoded-mode ram writes always go to bank A.
// RQ7 - The random-access variant takes the digit address from three address pins, pin zero least significant.
// RQ8 - The random-access variant writes the addressed digit on the rising strobe and has no control word.
// RQ9 - In the random-access variant a low point input lights that digit's decimal point.
// RQ10 - The three-level function input selects hex when high, code B when floating, shutdown when low.
// RQ11 - Bit seven requests a sequential update in a control word and carries point data in a ram word.
// RQ12 - Control bit five selects undecoded display when high and decoded when low.
// RQ13 - Control bit six selects hex decoding when high and code B when low.
// RQ14 - After a pending control word eight ram writes fill digits one to eight blanked, then writes are ignored.
// RQ15 - The control settings stay unchanged until the next write with target select high.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "ledwp_cfg.svh"
module ledwp_top (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_write_strobe,
  input  wire logic        i_target_select,
  input  wire logic [7:0]  i_data_in_line,
  input  wire logic [2:0]  i_digit_addr,
  input  wire logic        i_func_is_high,
  input  wire logic        i_func_is_low,
  output logic             o_osc_display_off,
  output logic             o_display_blank,
  output logic             o_no_decode,
  output logic             o_hex_decode,
  output logic             o_bank_a
);
  logic                      rst_b_sync;
  logic [`LEDWP_PIN_W-1:0]   pins_s;
  logic                      wr_s;
  logic                      sel_s;
  logic [7:0]                din_s;
  logic [2:0]                da_s;
  logic                      fh_s;
  logic                      fl_s;
  logic                      wr_d_reg;
  logic                      rise;

  // reset release and pin synchronisers
  ledwp_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_ce    (1'b1),
    .i_d     (1'b1),
    .o_q     (rst_b_sync)
  );

  ledwp_sync #(.W(`LEDWP_PIN_W), .RST_VAL(`LEDWP_PIN_RST)) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_rst_b (rst_b_sync),
    .i_ce    (i_clk_en),
    .i_d     ({i_func_is_low, i_func_is_high, i_digit_addr, i_data_in_line, i_target_select, i_write_strobe}),
    .o_q     (pins_s)
  );

  assign {fl_s, fh_s, da_s, din_s, sel_s, wr_s} = pins_s;

  always_ff @(posedge i_mclk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      wr_d_reg <= 1'b1;
    end else if (i_clk_en) begin
      wr_d_reg <= wr_s;
    end
  end

  assign rise = i_clk_en & wr_s & ~wr_d_reg;

  // write engine state
  logic [7:0]               ctrl_reg,  ctrl_next;
  ledwp_pkg::ledwp_state_t  st_reg,    st_next;
  logic [2:0]               cnt_reg,   cnt_next;
  logic [2:0]               addr_reg,  addr_next;
  logic                     blank_reg, blank_next;
  logic                     cfg_rand_reg, cfg_rand_next;
  logic [7:0]               ram_reg [`LEDWP_WORDS];
  logic [`LEDWP_DIGITS-1:0] dp_reg;
  logic                     ram_we;
  logic [3:0]               ram_idx;
  logic [7:0]               ram_wd;
  logic [2:0]               dig;
  logic                     dp_bit;
  logic                     bank_sel;

  always_comb begin
    ctrl_next  = ctrl_reg;
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    blank_next = blank_reg;
    ram_we     = 1'b0;
    dig        = `LEDWP_FIRST_DIGIT;
    ram_wd     = din_s;                                     // RQ4
    dp_bit     = din_s[`LEDWP_PEND_BIT];                    // RQ11
    bank_sel   = ctrl_reg[`LEDWP_NODEC_BIT] ? `LEDWP_BANK_A : ctrl_reg[`LEDWP_BANK_BIT]; // RQ6
    if (cfg_rand_reg) begin
      bank_sel = `LEDWP_BANK_A;
      ram_wd   = {4'h0, din_s[`LEDWP_HEX_DATA_MSB:0]};
      dp_bit   = ~din_s[`LEDWP_PEND_BIT];                   // RQ9
    end
    if (rise) begin
      if (cfg_rand_reg) begin
        ram_we = 1'b1;                                      // RQ8
        dig    = da_s;                                      // RQ7
      end else if (sel_s) begin
        ctrl_next = din_s;                                  // RQ1 RQ2
        addr_next = din_s[`LEDWP_ADDR_MSB:`LEDWP_ADDR_LSB]; // RQ5
        cnt_next  = `LEDWP_FIRST_DIGIT;
        if (din_s[`LEDWP_PEND_BIT]) begin
          st_next    = ledwp_pkg::LEDWP_ST_SEQ;             // RQ11 RQ14
          blank_next = 1'b1;
        end else begin
          st_next    = ledwp_pkg::LEDWP_ST_SINGLE;
          blank_next = 1'b0;
        end
      end else begin
        case (st_reg)
          ledwp_pkg::LEDWP_ST_SEQ: begin
            ram_we   = 1'b1;                                // RQ14
            dig      = cnt_reg;
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == `LEDWP_LAST_DIGIT) begin
              st_next    = ledwp_pkg::LEDWP_ST_HOLD;
              blank_next = 1'b0;
            end
          end
          ledwp_pkg::LEDWP_ST_SINGLE: begin
            ram_we = 1'b1;                                  // RQ2
            dig    = addr_reg;                              // RQ5
          end
          ledwp_pkg::LEDWP_ST_HOLD: begin
            ram_we = 1'b0;                                  // RQ14
          end
          default: begin
            st_next = ledwp_pkg::LEDWP_ST_SINGLE;
          end
        endcase
      end
    end
    ram_idx = {bank_sel, dig};
  end

  always_ff @(posedge i_mclk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      ctrl_reg  <= `LEDWP_CTRL_RST;
      st_reg    <= ledwp_pkg::LEDWP_ST_SINGLE;
      cnt_reg   <= `LEDWP_FIRST_DIGIT;
      addr_reg  <= `LEDWP_FIRST_DIGIT;
      blank_reg <= 1'b0;
      dp_reg    <= '0;
      for (int i = 0; i < `LEDWP_WORDS; i++) begin
        ram_reg[i] <= 8'h00;
      end
    end else if (i_clk_en) begin
      ctrl_reg  <= ctrl_next;                               // RQ15
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      blank_reg <= blank_next;
      if (ram_we) begin
        ram_reg[ram_idx] <= ram_wd;
        dp_reg[dig]      <= dp_bit;
      end
    end
  end

  // display settings to the scan logic
  logic off_next, blank_o_next, nodec_next, hex_next, banka_next;

  always_comb begin
    if (cfg_rand_reg) begin
      off_next   = fl_s;                                    // RQ10
      hex_next   = fh_s;
      nodec_next = 1'b0;
      banka_next = `LEDWP_BANK_A;
    end else begin
      off_next   = ~ctrl_reg[`LEDWP_LOWPWR_BIT];            // RQ3
      hex_next   = ctrl_reg[`LEDWP_HEX_BIT];                // RQ13
      nodec_next = ctrl_reg[`LEDWP_NODEC_BIT];              // RQ12
      banka_next = ctrl_reg[`LEDWP_BANK_BIT];               // RQ6
    end
    blank_o_next = off_next | (blank_reg & ~cfg_rand_reg);  // RQ14
  end

  always_ff @(posedge i_mclk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      o_osc_display_off <= 1'b0;
      o_display_blank   <= 1'b0;
      o_no_decode       <= 1'b0;
      o_hex_decode      <= 1'b0;
      o_bank_a          <= 1'b0;
    end else if (i_clk_en) begin
      o_osc_display_off <= off_next;
      o_display_blank   <= blank_o_next;
      o_no_decode       <= nodec_next;
      o_hex_decode      <= hex_next;
      o_bank_a          <= banka_next;
    end
  end

  // apb slave, zero wait states
  logic        setup;
  logic        access;
  logic        hit;
  logic [31:0] rdata_next;

  assign setup    = i_psel & ~i_penable;
  assign access   = i_psel & i_penable;
  assign o_pready = 1'b1;

  always_comb begin
    hit        = 1'b1;
    rdata_next = o_prdata;
    if (i_paddr[7:6] == `LEDWP_RAM_BASE_HI && i_paddr[1:0] == 2'h0) begin
      rdata_next = {24'h000000, ram_reg[i_paddr[5:2]]};
    end else begin
      case (i_paddr)
        `LEDWP_OFS_CFG:   rdata_next = {31'h00000000, cfg_rand_reg};
        `LEDWP_OFS_STAT:  rdata_next = {16'h0000, 1'b0, cnt_reg, 1'b0, blank_reg, st_reg, ctrl_reg};
        `LEDWP_OFS_POINT: rdata_next = {24'h000000, dp_reg};
        default:          hit = 1'b0;
      endcase
    end
    if (!setup) begin
      rdata_next = o_prdata;
    end
    cfg_rand_next = cfg_rand_reg;
    if (access && i_pwrite && i_paddr == `LEDWP_OFS_CFG) begin
      cfg_rand_next = i_pwdata[`LEDWP_CFG_RAND_BIT];
    end
  end

  assign o_pslverr = access & ~hit;

  always_ff @(posedge i_mclk or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      o_prdata     <= 32'h00000000;
      cfg_rand_reg <= `LEDWP_CFG_RST;
    end else if (i_clk_en) begin
      o_prdata     <= rdata_next;
      cfg_rand_reg <= cfg_rand_next;
    end
  end

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_b_sync);

  sequence s_ctrl_pend;
    rise && !cfg_rand_reg && sel_s && din_s[`LEDWP_PEND_BIT];
  endsequence

  sequence s_last_seq_write;
    rise && !cfg_rand_reg && !sel_s && st_reg == ledwp_pkg::LEDWP_ST_SEQ && cnt_reg == `LEDWP_LAST_DIGIT;
  endsequence

  AST_CTRL_LOAD: assert property (rise && !cfg_rand_reg && sel_s |=> ctrl_reg == $past(din_s)) // RQ1
    else $error("control word not captured");
  AST_CTRL_HOLD: assert property (!(rise && !cfg_rand_reg && sel_s) |=> $stable(ctrl_reg)) // RQ15
    else $error("control word changed without a control write");
  AST_RAM_DATA: assert property (ram_we && !cfg_rand_reg |=> ram_reg[$past(ram_idx)] == $past(din_s)) // RQ4
    else $error("ram word differs from written byte");
  AST_SINGLE_ADDR: assert property (ram_we && st_reg == ledwp_pkg::LEDWP_ST_SINGLE && !cfg_rand_reg
                                    |-> dig == addr_reg) // RQ5
    else $error("single digit write went to the wrong digit");
  AST_BANK: assert property (ram_we && !cfg_rand_reg && !ctrl_reg[`LEDWP_NODEC_BIT]
                             |-> ram_idx[3] == ctrl_reg[`LEDWP_BANK_BIT]) // RQ6
    else $error("decoded write went to the wrong bank");
  AST_LOWPWR: assert property (i_clk_en && !cfg_rand_reg && !ctrl_reg[`LEDWP_LOWPWR_BIT]
                               |=> o_osc_display_off && o_display_blank) // RQ3
    else $error("low power not applied");
  AST_DECODE: assert property (i_clk_en && !cfg_rand_reg
                               |=> o_no_decode == $past(ctrl_reg[`LEDWP_NODEC_BIT])) // RQ12
    else $error("decode select not followed");
  AST_SCHEME: assert property (i_clk_en && !cfg_rand_reg
                               |=> o_hex_decode == $past(ctrl_reg[`LEDWP_HEX_BIT])) // RQ13
    else $error("scheme select not followed");
  AST_SEQ_START: assert property (s_ctrl_pend |=> st_reg == ledwp_pkg::LEDWP_ST_SEQ && blank_reg
                                  && cnt_reg == `LEDWP_FIRST_DIGIT) // RQ14
    else $error("sequential update did not start blanked at digit one");
  AST_SEQ_END: assert property (s_last_seq_write |=> st_reg == ledwp_pkg::LEDWP_ST_HOLD && !blank_reg) // RQ14
    else $error("sequential update did not end after eighth write");
  AST_HOLD_IGNORE: assert property (st_reg == ledwp_pkg::LEDWP_ST_HOLD && !cfg_rand_reg && !sel_s |-> !ram_we) // RQ14
    else $error("write accepted after sequence end");
  AST_RAND_ADDR: assert property (rise && cfg_rand_reg |-> ram_we && dig == da_s && $stable(ctrl_reg)) // RQ7
    else $error("random access write misaddressed");
  AST_RAND_POINT: assert property (rise && cfg_rand_reg && !din_s[`LEDWP_PEND_BIT] |=> dp_reg[$past(da_s)]) // RQ9
    else $error("active low point not stored lit");
  AST_FUNC: assert property (i_clk_en && cfg_rand_reg && fl_s |=> o_osc_display_off && o_display_blank) // RQ10
    else $error("function low did not shut down");
endmodule

// file: src/ledwp_cfg.svh
// constants for the led display write port: field positions, offsets, resets
// assumes inclusion by bare name from the design files
`ifndef LEDWP_CFG_SVH
`define LEDWP_CFG_SVH

// control word fields
`define LEDWP_ADDR_MSB     2
`define LEDWP_ADDR_LSB     0
`define LEDWP_BANK_BIT     3
`define LEDWP_LOWPWR_BIT   4
`define LEDWP_NODEC_BIT    5
`define LEDWP_HEX_BIT      6
`define LEDWP_PEND_BIT     7
`define LEDWP_CTRL_RST     8'h10

// display ram shape
`define LEDWP_DIGITS       8
`define LEDWP_WORDS        16
`define LEDWP_LAST_DIGIT   3'h7
`define LEDWP_FIRST_DIGIT  3'h0
`define LEDWP_BANK_A       1'b1
`define LEDWP_HEX_DATA_MSB 3

// pin synchroniser: strobe at bit 0 idles high
`define LEDWP_PIN_W        15
`define LEDWP_PIN_RST      15'h0001

// apb map
`define LEDWP_OFS_CFG      8'h00
`define LEDWP_OFS_STAT     8'h04
`define LEDWP_OFS_POINT    8'h08
`define LEDWP_RAM_BASE_HI  2'h1
`define LEDWP_CFG_RAND_BIT 0
`define LEDWP_CFG_RST      1'b0

`endif

// file: src/ledwp_pkg.sv
// types of the led display write port
// assumes nothing of its surroundings
package ledwp_pkg;
  typedef enum logic [1:0] {
    LEDWP_ST_SINGLE,
    LEDWP_ST_SEQ,
    LEDWP_ST_HOLD
  } ledwp_state_t;
endpackage

// file: src/ledwp_sync.sv
// two-flop synchroniser for a group of levels
// assumes levels that change slower than the clock
`timescale 1ns/1ps
module ledwp_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = i_ce ? i_d : meta_reg;
    q_next    = i_ce ? meta_reg : o_q;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= RST_VAL;
      o_q      <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      o_q      <= q_next;
    end
  end
endmodule

// file: testbench/ledwp_host_model.sv
// microprocessor model driving the display write pins
// assumes one write_pins call at a time, after reset release
`timescale 1ns/1ps
module ledwp_host_model (
  input  wire logic       i_mclk,
  output logic            o_write_strobe,
  output logic            o_target_select,
  output logic      [7:0] o_data_in_line,
  output logic      [2:0] o_digit_addr
);
  initial begin
    o_write_strobe  = 1'b1;
    o_target_select = 1'b0;
    o_data_in_line  = 8'h00;
    o_digit_addr    = 3'h0;
  end
  // setup with strobe low, rise, hold, then release to the inverse
  task automatic write_pins(input logic sel, input logic [7:0] d, input logic [2:0] a);
    @(posedge i_mclk);
    o_target_select <= sel;
    o_data_in_line  <= d;
    o_digit_addr    <= a;
    o_write_strobe  <= 1'b0;
    repeat (6) @(posedge i_mclk);
    o_write_strobe <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_data_in_line <= ~d;
    o_digit_addr   <= ~a;
    repeat (6) @(posedge i_mclk);
  endtask
endmodule

// file: testbench/led_display_write_port_tb.sv
// self-checking bench of the led display write port
// assumes ledwp_top and the host model; apb tasks read back state
`timescale 1ns/1ps
module led_display_write_port_tb;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0]  paddr, cw [5];
  logic [31:0] pwdata, prdata, rdat;
  logic        strobe, tsel, fhi, flo, osc_off, blank, nodec, hex, bank_a, ce;
  logic [7:0]  dline;
  logic [2:0]  daddr;
  logic [4:0]  outs;
  int          n_mismatch, compares;
  assign outs = {osc_off, blank, nodec, hex, bank_a};
  ledwp_top i_dut (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_clk_en(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_write_strobe(strobe), .i_target_select(tsel), .i_data_in_line(dline),
    .i_digit_addr(daddr), .i_func_is_high(fhi), .i_func_is_low(flo), .o_osc_display_off(osc_off),
    .o_display_blank(blank), .o_no_decode(nodec), .o_hex_decode(hex), .o_bank_a(bank_a)
  );
  ledwp_host_model i_host (
    .i_mclk(mclk), .o_write_strobe(strobe), .o_target_select(tsel),
    .o_data_in_line(dline), .o_digit_addr(daddr)
  );
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    compares++;
    if ((g & m) !== (e & m)) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g & m, e & m);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, m);
  endtask
  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    fhi = 1'b0; flo = 1'b0; n_mismatch = 0; compares = 0; ce = 1'b1;
    cw = '{8'h00, 8'h18, 8'h30, 8'h50, 8'h5d};
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(outs, 32'h0, 32'h1f);
    rd(8'h04, 32'hff, 32'h10);
    rd(8'h00, 32'h1, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk(serr, 1'b1, 32'h1);
    $display("test reset done");
    // control word fields, pending bit low
    for (int i = 0; i < 5; i++) begin
      i_host.write_pins(1'b1, cw[i], 3'h0);
      chk(outs, {~cw[i][4], ~cw[i][4], cw[i][5], cw[i][6], cw[i][3]}, cw[i][5] ? 32'h1e : 32'h1f);
      rd(8'h04, 32'hff, cw[i]);
    end
    // strobe while frozen must leave the settings alone
    ce <= 1'b0;
    i_host.write_pins(1'b1, 8'h00, 3'h0);
    chk(outs, 32'h03, 32'h1f);
    ce <= 1'b1;
    $display("test control done");
    // single digit: last word addressed digit 5 of bank A
    i_host.write_pins(1'b0, 8'h95, 3'h0);
    rd(8'h74, 32'h1f, 32'h15);
    rd(8'h08, 32'h20, 32'h20);
    rd(8'h04, 32'hff, 32'h5d);
    i_host.write_pins(1'b1, 8'h12, 3'h0);
    i_host.write_pins(1'b0, 8'h0a, 3'h0);
    rd(8'h48, 32'h1f, 32'h0a);
    rd(8'h08, 32'h04, 32'h00);
    $display("test single done");
    // sequential update into bank A, ninth write ignored
    i_host.write_pins(1'b1, 8'h98, 3'h0);
    chk(blank, 1'b1, 32'h1);
    rd(8'h04, 32'h300, 32'h100);
    for (int i = 0; i < 8; i++) begin
      i_host.write_pins(1'b0, 8'(i + 1), 3'h0);
      chk(blank, i != 7, 32'h1);
    end
    rd(8'h04, 32'h300, 32'h200);
    i_host.write_pins(1'b0, 8'h0f, 3'h0);
    for (int i = 0; i < 8; i++) begin
      rd(8'(8'h60 + 4 * i), 32'h0f, 32'(i + 1));
    end
    $display("test sequential done");
    // random-access variant
    apb(1'b1, 8'h00, 32'h1);
    rd(8'h00, 32'h1, 32'h1);
    i_host.write_pins(1'b0, 8'h0c, 3'h3);
    i_host.write_pins(1'b1, 8'h83, 3'h6);
    rd(8'h6c, 32'hff, 32'h0c);
    rd(8'h78, 32'hff, 32'h03);
    rd(8'h08, 32'h48, 32'h08);
    for (int i = 0; i < 3; i++) begin
      fhi <= (i == 0);
      flo <= (i == 2);
      repeat (6) @(posedge mclk);
      chk({osc_off, hex}, {i == 2, i == 0}, 32'h3);
    end
    $display("test random done");
    report_and_stop();
  end
endmodule
